//--- pkg/iss_pkg.sv
// Package of constants for the interrupt source selector.
package iss_pkg;
    localparam logic [31:0] ADDR_HIGH     = 32'h019C_0000;
    localparam logic [31:0] ADDR_LOW      = 32'h019C_0004;
    localparam logic [31:0] ADDR_STATUS   = 32'h019C_0008;
    localparam logic [31:0] ADDR_MASK     = 32'h019C_000C;
    localparam int          FIELD_W       = 5;
    localparam int          NUM_LINES     = 16;
    localparam int          NUM_SEL       = 12;
    localparam int          FIRST_SEL     = 4;
    localparam int          NUM_SRC       = 32;
    // Low bit of each selector field in its register, for lines 4..15.
    localparam int          FIELD_LSB [6] = '{0, 5, 10, 16, 21, 26};
    localparam logic [31:0] USED_BITS     = 32'h7FFF_7FFF;
    localparam logic [31:0] LOW_RESET     = 32'h2507_18A4;
    localparam logic [31:0] HIGH_RESET    = 32'h0820_2D43;
    localparam logic [11:0] MASK_RESET    = 12'h000;
    localparam logic [4:0]  CODE_RSV_A    = 5'h15;
    localparam logic [4:0]  CODE_RSV_B    = 5'h16;
    localparam logic [4:0]  CODE_RSV_LO   = 5'h18;
    localparam logic [4:0]  CODE_RSV_HI   = 5'h1D;
endpackage

//--- pkg/iss_sel_if.sv
// Interface carrying selector codes and routed lines between modules.
`timescale 1ns/100ps
interface iss_sel_if;
    logic [59:0] codes;
    logic [31:0] events;
    logic [11:0] lines;
    modport ctrl (output codes, output events, input lines);
    modport mux  (input codes, input events, output lines);
endinterface

//--- rtl/iss_mux.sv
// Twelve 32-to-1 selectors that route an event onto each programmable line.
`timescale 1ns/100ps
module iss_mux (
    iss_sel_if.mux sel
);
    genvar g;
    generate
        for (g = 0; g < iss_pkg::NUM_SEL; g++) begin : g_line
            // Every code picks its event; reserved inputs are tied low above.
            assign sel.lines[g] = sel.events[sel.codes[g*5 +: 5]];
        end
    endgenerate
endmodule

//--- rtl/iss_top.sv
// Interrupt source selector: registers, routing, priority and interrupt.
// How it works
// - Lines 0 to 3 come straight from reset, NMI and two tied-low lines.
// - Lines 4 to 15 each take the event chosen by a 5-bit selector field.
// - Lines 4 to 7 use low fields 4:0, 9:5, 14:10, 20:16, reset codes 4 to 7.
// - Lines 8 and 9 use low fields 25:21 and 30:26, reset codes 8 and 9.
// - Lines 10 to 12 use high fields 4:0, 9:5, 14:10, reset codes 3, 10, 11.
// - Lines 13 to 15 use high fields 20:16, 25:21, 30:26, reset codes 0, 1, 2.
// - Codes 12 to 20 select the serial, GPIO 0, timer 2 and port B events.
// - Codes 23, 30 and 31 select the cell bus, Viterbi and turbo events.
// - After reset the shared pins act as external interrupt inputs only.
// - Line 0 has the highest priority and line 15 the lowest.
// - The high register is at 0x019C0000 and the low one at 0x019C0004.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
module iss_top (
    input  wire  logic        mclk,
    input  wire  logic        nrst,
    input  wire  logic        clk_en,
    input  wire  logic [31:0] addr,
    input  wire  logic [31:0] wdata,
    input  wire  logic        wr_stb,
    input  wire  logic        rd_stb,
    output logic [31:0]       rdata,
    input  wire  logic        reset_event,
    input  wire  logic        nmi_event,
    input  wire  logic [3:0]  external_irq_pin,
    input  wire  logic        host_port_event,
    input  wire  logic        timer0_event,
    input  wire  logic        timer1_event,
    input  wire  logic        port_a_sdram_timer_event,
    input  wire  logic        dma_completion_event,
    input  wire  logic        emulation_dma_event,
    input  wire  logic        debug_exchange_rx_event,
    input  wire  logic        debug_exchange_tx_event,
    input  wire  logic        serial0_tx_event,
    input  wire  logic        serial0_rx_event,
    input  wire  logic        serial1_tx_event,
    input  wire  logic        serial1_rx_event,
    input  wire  logic        gpio_event_0,
    input  wire  logic        serial2_tx_event,
    input  wire  logic        serial2_rx_event,
    input  wire  logic        timer2_event,
    input  wire  logic        port_b_sdram_timer_event,
    input  wire  logic        cell_bus_event,
    input  wire  logic        viterbi_coproc_event,
    input  wire  logic        turbo_coproc_event,
    output logic [15:0]       cpu_int_lines,
    output logic [3:0]        top_line_id,
    output logic              top_line_valid,
    output logic              irq
);
    logic [31:0] low_r;
    logic [31:0] high_r;
    logic [11:0] status_r;
    logic [11:0] mask_r;
    logic [31:0] rdata_nxt;
    logic [15:0] lines_nxt;
    logic [11:0] rise;
    logic [11:0] prev_r;
    logic [3:0]  top_nxt;

    iss_sel_if sel ();

    // Event table, index equals selector code; reserved codes read zero.
    assign sel.events = {turbo_coproc_event, viterbi_coproc_event,
                         6'h00,
                         cell_bus_event,
                         2'b00,
                         port_b_sdram_timer_event, timer2_event,
                         serial2_rx_event, serial2_tx_event,
                         gpio_event_0,
                         serial1_rx_event, serial1_tx_event,
                         serial0_rx_event, serial0_tx_event,
                         debug_exchange_tx_event,
                         debug_exchange_rx_event,
                         emulation_dma_event, dma_completion_event,
                         external_irq_pin,
                         port_a_sdram_timer_event, timer1_event,
                         timer0_event, host_port_event};

    // Field lists follow the line order 4..15.
    function automatic logic [4:0] field(input logic [31:0] r, input int k);
        field = r[iss_pkg::FIELD_LSB[k] +: iss_pkg::FIELD_W];
    endfunction

    assign sel.codes = {field(high_r, 5), field(high_r, 4),
                        field(high_r, 3),
                        field(high_r, 2), field(high_r, 1),
                        field(high_r, 0),
                        field(low_r, 5), field(low_r, 4),
                        field(low_r, 3), field(low_r, 2),
                        field(low_r, 1), field(low_r, 0)};

    iss_mux u_mux (
        .sel (sel)
    );

    wire hit_low  = (addr == iss_pkg::ADDR_LOW);
    wire hit_high = (addr == iss_pkg::ADDR_HIGH);
    wire hit_stat = (addr == iss_pkg::ADDR_STATUS);
    wire hit_mask = (addr == iss_pkg::ADDR_MASK);

    // Lines 2 and 3 are reserved and held low.
    assign lines_nxt = {sel.lines, 2'b00, nmi_event, reset_event};

    assign rise = sel.lines & ~prev_r;

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (rd_stb) begin
            if (hit_low)
                rdata_nxt = low_r & iss_pkg::USED_BITS;
            else if (hit_high)
                rdata_nxt = high_r & iss_pkg::USED_BITS;
            else if (hit_stat)
                rdata_nxt = {20'h0_0000, status_r};
            else if (hit_mask)
                rdata_nxt = {20'h0_0000, mask_r};
        end
    end

    // Fixed priority: lowest numbered active line wins.
    always_comb begin
        top_nxt = 4'h0;
        for (int i = iss_pkg::NUM_LINES - 1; i >= 0; i--) begin
            if (lines_nxt[i])
                top_nxt = 4'(i);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            low_r  <= iss_pkg::LOW_RESET;
            high_r <= iss_pkg::HIGH_RESET;
        end else if (clk_en && wr_stb) begin
            // Writes take effect the next cycle for routing.
            if (hit_low)
                low_r <= wdata & iss_pkg::USED_BITS;
            if (hit_high)
                high_r <= wdata & iss_pkg::USED_BITS;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mask_r <= iss_pkg::MASK_RESET;
        end else if (clk_en && wr_stb && hit_mask) begin
            mask_r <= wdata[11:0];
        end
    end

    // A rising line sets its sticky bit; a status read clears, set wins.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            status_r <= 12'h000;
            prev_r   <= 12'h000;
        end else if (clk_en) begin
            prev_r <= sel.lines;
            if (rd_stb && hit_stat)
                status_r <= rise;
            else
                status_r <= status_r | rise;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata          <= 32'h0000_0000;
            cpu_int_lines  <= 16'h0000;
            top_line_id    <= 4'h0;
            top_line_valid <= 1'b0;
            irq            <= 1'b0;
        end else if (clk_en) begin
            rdata          <= rdata_nxt;
            cpu_int_lines  <= lines_nxt;
            top_line_id    <= top_nxt;
            top_line_valid <= |lines_nxt;
            irq            <= |(status_r & mask_r);
        end
    end

    a_reserved_low: assert property (@(posedge mclk) disable iff (!nrst)
        !cpu_int_lines[2] && !cpu_int_lines[3])
        else $error("reserved lines driven");

    a_nmi_follows: assert property (@(posedge mclk) disable iff (!nrst)
        clk_en |=> cpu_int_lines[1] == $past(nmi_event))
        else $error("nmi line wrong");

    a_line4_route: assert property (@(posedge mclk) disable iff (!nrst)
        clk_en |=> cpu_int_lines[4] ==
            $past(sel.events[low_r[4:0]]))
        else $error("line 4 misrouted");

    a_line15_route: assert property (@(posedge mclk) disable iff (!nrst)
        clk_en |=> cpu_int_lines[15] ==
            $past(sel.events[high_r[30:26]]))
        else $error("line 15 misrouted");

    a_unused_zero: assert property (@(posedge mclk) disable iff (!nrst)
        !low_r[15] && !low_r[31] && !high_r[15] && !high_r[31])
        else $error("unused bits set");

    a_write_takes: assert property (@(posedge mclk) disable iff (!nrst)
        clk_en && wr_stb && hit_high |=>
            high_r == ($past(wdata) & iss_pkg::USED_BITS))
        else $error("high write lost");

    a_priority_top: assert property (@(posedge mclk) disable iff (!nrst)
        top_line_valid |-> cpu_int_lines[top_line_id] &&
            ((cpu_int_lines & ((16'h0001 << top_line_id) - 16'h0001))
             == 16'h0000))
        else $error("priority wrong");

    a_timer2_code: assert property (@(posedge mclk) disable iff (!nrst)
        sel.events[19] == timer2_event &&
        sel.events[31] == turbo_coproc_event)
        else $error("code table wrong");

    a_reserved_code: assert property (@(posedge mclk) disable iff (!nrst)
        sel.events[21] == 1'b0 && sel.events[24] == 1'b0)
        else $error("reserved code live");
endmodule

//--- tb/iss_src_model.sv
// Peripheral event sources standing behind the selector's event inputs.
`timescale 1ns/100ps
module iss_src_model (
    input  wire logic [31:0] ev,
    output logic [31:0]      src
);
    // Reserved codes have no peripheral behind them, so they stay low.
    assign src = ev & ~32'h3F60_0000;
endmodule

//--- tb/testbench.sv
// Self-checking bench for the interrupt source selector.
`timescale 1ns/100ps
module testbench;
    logic        mclk;
    logic        nrst;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic [31:0] ev;
    logic [31:0] src;
    logic [1:0]  fx;
    logic [15:0] lines;
    logic [3:0]  top_id;
    logic        top_v;
    logic        irq;
    logic        ln_req;
    logic        rd_q;
    logic        ln_q;
    logic        en;
    logic [21:0] ln_last;
    logic [31:0] rd_exp[$];
    logic [21:0] ln_exp[$];
    logic [31:0] sel_lo;
    logic [31:0] sel_hi;
    logic [11:0] st;
    logic [11:0] msk;
    logic [15:0] prev;
    int          n_errors;
    int          n_compared;
    int          cyc;

    iss_src_model u_src (.ev(ev), .src(src));
    iss_top u_dut (.mclk(mclk), .nrst(nrst), .clk_en(en), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .reset_event(fx[0]), .nmi_event(fx[1]),
        .external_irq_pin(src[7:4]), .host_port_event(src[0]),
        .timer0_event(src[1]), .timer1_event(src[2]),
        .port_a_sdram_timer_event(src[3]), .dma_completion_event(src[8]),
        .emulation_dma_event(src[9]), .debug_exchange_rx_event(src[10]),
        .debug_exchange_tx_event(src[11]), .serial0_tx_event(src[12]),
        .serial0_rx_event(src[13]), .serial1_tx_event(src[14]),
        .serial1_rx_event(src[15]), .gpio_event_0(src[16]),
        .serial2_tx_event(src[17]), .serial2_rx_event(src[18]),
        .timer2_event(src[19]), .port_b_sdram_timer_event(src[20]),
        .cell_bus_event(src[23]), .viterbi_coproc_event(src[30]),
        .turbo_coproc_event(src[31]), .cpu_int_lines(lines),
        .top_line_id(top_id), .top_line_valid(top_v), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic rsv(input logic [4:0] c);
        return c == iss_pkg::CODE_RSV_A || c == iss_pkg::CODE_RSV_B ||
               (c >= iss_pkg::CODE_RSV_LO && c <= iss_pkg::CODE_RSV_HI);
    endfunction

    function automatic logic [31:0] pick();
        logic [31:0] v;
        logic [4:0]  c;
        v = 32'h0000_0000;
        for (int k = 0; k < 6; k++) begin
            do c = 5'($urandom); while (rsv(c));
            v[iss_pkg::FIELD_LSB[k] +: 5] = c;
        end
        return v;
    endfunction

    task automatic summarize();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp_rd(input logic [31:0] e);
        n_compared++;
        if (rdata !== e) begin
            n_errors++;
            $display("ERROR %0t read %h expected %h", $time, rdata, e);
        end
    endtask

    task automatic cmp_ln(input logic [21:0] e);
        n_compared++;
        if ({top_v, top_id, irq, lines} !== e) begin
            n_errors++;
            $display("ERROR %0t lines %h expected %h", $time,
                     {top_v, top_id, irq, lines}, e);
        end
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge mclk);
        rd_exp.push_back(e);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask

    // Events are held steady for several cycles, so one rise per step.
    task automatic apply(input logic [31:0] e);
        logic [15:0] l;
        logic [4:0]  c;
        logic [3:0]  id;
        logic [1:0]  f;
        f = 2'($urandom);
        l = {14'h0000, f};
        for (int n = 4; n < 16; n++) begin
            c = n < 10 ? sel_lo[iss_pkg::FIELD_LSB[n - 4] +: 5]
                       : sel_hi[iss_pkg::FIELD_LSB[n - 10] +: 5];
            l[n] = e[c] & ~rsv(c);
        end
        id = 4'h0;
        for (int n = 15; n >= 0; n--)
            if (l[n])
                id = 4'(n);
        st   = st | (l[15:4] & ~prev[15:4]);
        prev = l;
        ln_last = {|l, id, |(st & msk), l};
        ln_exp.push_back(ln_last);
        @(posedge mclk);
        ev <= e;
        fx <= f;
        repeat (3) @(posedge mclk);
        ln_req <= 1'b1;
        @(posedge mclk);
        ln_req <= 1'b0;
    endtask

    // With the enable low the lines, priority and irq outputs must hold, whatever the inputs do.
    task automatic freeze();
        logic [31:0] e0;
        e0 = ev;
        ln_exp.push_back(ln_last);
        @(posedge mclk);
        en <= 1'b0;
        ev <= ~e0 & ~32'h3F60_0000;
        fx <= ~fx;
        repeat (3) @(posedge mclk);
        ln_req <= 1'b1;
        @(posedge mclk);
        ln_req <= 1'b0;
        @(posedge mclk);
        en <= 1'b1;
        ev <= e0;
        fx <= ~fx;
        repeat (2) @(posedge mclk);
    endtask

    task automatic sweep();
        for (int c = 0; c < 32; c++)
            apply(32'h0000_0001 << c);
        apply(32'h0000_0000);
        rd(iss_pkg::ADDR_STATUS, {20'h0_0000, st});
        st = 12'h000;
        msk = 12'($urandom);
        wr(iss_pkg::ADDR_MASK, {20'h0_0000, msk});
        rd(iss_pkg::ADDR_MASK, {20'h0_0000, msk});
    endtask

    always @(posedge mclk) begin
        if (rd_q)
            cmp_rd(rd_exp.pop_front());
        if (ln_q)
            cmp_ln(ln_exp.pop_front());
        rd_q <= rd_stb;
        ln_q <= ln_req;
        cyc  <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        n_errors = 0;
        n_compared = 0;
        cyc = 0;
        nrst = 1'b0;
        {addr, wdata, wr_stb, rd_stb, ev, fx, ln_req, rd_q, ln_q} = '0;
        sel_lo = iss_pkg::LOW_RESET;
        sel_hi = iss_pkg::HIGH_RESET;
        {st, msk, prev} = '0;
        en = 1'b1;
        void'($urandom(32'h0be5_9b20));
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd(iss_pkg::ADDR_LOW, iss_pkg::LOW_RESET);
        rd(iss_pkg::ADDR_HIGH, iss_pkg::HIGH_RESET);
        rd(iss_pkg::ADDR_MASK, 32'h0000_0000);
        rd(32'h019C_0010, 32'h0000_0000);
        sweep();
        freeze();
        repeat (3) begin
            sel_lo = pick();
            sel_hi = pick();
            wr(iss_pkg::ADDR_LOW, sel_lo | 32'h8000_8000);
            wr(iss_pkg::ADDR_HIGH, sel_hi | 32'h8000_8000);
            rd(iss_pkg::ADDR_LOW, sel_lo);
            rd(iss_pkg::ADDR_HIGH, sel_hi);
            sweep();
        end
        repeat (4) @(posedge mclk);
        summarize();
    end
endmodule
